// ### sbcfg_host_model.sv
/*
 * Behavioural SMBus host controller facing the configuration port.
 * Assumes the bench resolves SDA as an open-drain wire with a pull-up.
 */
`timescale 1ns/1ps
`default_nettype none
module sbcfg_host_model (
	input  wire logic       sys_clk,
	input  wire logic       sda_wire,
	output logic            scl,
	output logic            sda_pull,
	output logic            res_valid,
	output logic [8:0]      res_data
);
	// ----------------------------------------
	// Bit timing: 48 ns SCL, data moves mid-low
	// ----------------------------------------
	localparam int QTR = 12;

	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
		res_valid = 1'b0;
		res_data = 9'h000;
	end

	// Strobe spans negedge to negedge, so the watcher sees exactly one rising edge
	task automatic post(input logic [8:0] v);
	begin
		@(negedge sys_clk);
		res_data = v;
		res_valid = 1'b1;
		@(negedge sys_clk);
		res_valid = 1'b0;
	end
	endtask

	task automatic bit_io(input logic b, output logic r);
	begin
		scl = 1'b0;
		#QTR;
		sda_pull = ~b;
		#QTR;
		scl = 1'b1;
		#QTR;
		r = sda_wire;
		#QTR;
	end
	endtask

	// Serves as first start and repeated start alike
	task automatic start_c();
	begin
		scl = 1'b0;
		#QTR;
		sda_pull = 1'b0;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_pull = 1'b1;
		#QTR;
	end
	endtask

	task automatic stop_c();
	begin
		scl = 1'b0;
		#QTR;
		sda_pull = 1'b1;
		#QTR;
		scl = 1'b1;
		#QTR;
		sda_pull = 1'b0;
		#(QTR * 4);
	end
	endtask

	task automatic put_byte(input logic [7:0] v);
		logic r;
	begin
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], r);
		bit_io(1'b1, r);
		post({r, v});
	end
	endtask

	// Host acks all but the last byte, then leaves SDA high
	task automatic get_byte(input logic ack);
		logic [7:0] v;
		logic       r;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			v[i] = r;
		end
		bit_io(~ack, r);
		post({~ack, v});
	end
	endtask
endmodule
`default_nettype wire

// ### sbcfg_pkg.sv
/*
 * Shared constants and types for the configuration port with test-mode selection.
 * Assumes a single 200 MHz system clock domain; SMBus pins are sampled, not used as clocks.
 */
`default_nettype none
package sbcfg_pkg;
	// ----------------------------------------
	// Bus addresses and byte map
	// ----------------------------------------
	localparam logic [7:0] ADDR_WR      = 8'hd2;
	localparam logic [7:0] ADDR_RD      = 8'hd3;
	localparam int         NUM_BYTES    = 9;
	localparam logic [7:0] IDX_LIMIT    = 8'h09;
	localparam int         IDX_TEST     = 6;
	localparam int         IDX_ID       = 7;
	localparam int         IDX_COUNT    = 8;
	localparam int         POS_ENTRY    = 6;
	localparam int         POS_CHOICE   = 7;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [7:0] FILL_BYTE    = 8'hff;
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// ----------------------------------------
	// Reset values and writable bits, byte 8 first
	// ----------------------------------------
	localparam logic [8:0][7:0] RST_VAL = {8'h09, 8'h00, 8'h12, 8'h07, 8'h03, 8'h55, 8'h3f, 8'h9e, 8'hff};
	localparam logic [8:0][7:0] WR_MASK = {8'hff, 8'h00, 8'hc0, 8'h00, 8'h00, 8'hff, 8'h3f, 8'h9e, 8'hff};

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE   = 4'h0,
		ST_ADDR   = 4'h1,
		ST_INDEX  = 4'h2,
		ST_COUNT  = 4'h3,
		ST_WDATA  = 4'h4,
		ST_ACK    = 4'h5,
		ST_RDATA  = 4'h6,
		ST_RACK   = 4'h7,
		ST_RNEXT  = 4'h8,
		ST_IGNORE = 4'h9
	} sbcfg_state_t;

	typedef enum logic [1:0] {
		OUT_NORMAL = 2'h0,
		OUT_HIZ    = 2'h1,
		OUT_REFDIV = 2'h2
	} sbcfg_out_mode_t;

	typedef struct packed {
		logic [7:0] enable0;
		logic [7:0] enable1;
		logic [7:0] enable2;
		logic [7:0] amplitude;
	} sbcfg_cfg_t;
endpackage
`default_nettype wire

// ### sbcfg_port.sv
/*
 * SMBus target holding nine configuration bytes, with indexed block write and
 * block read, plus the test-mode output selection. resetn stands for power-up.
 * Assumes the host honours SMBus timing, so each SCL phase spans many sys_clk cycles.
 */
// Overview of operation
// - Acknowledge address byte d2 to start a write.
// - Acknowledge address byte d3 to start the read data phase.
// - Acknowledge the starting index byte following the write address.
// - Acknowledge the byte count before data bytes.
// - Store each data byte at successive indices and acknowledge each.
// - First returned byte is the byte count.
// - Then return bytes from index N onward in sequence.
// - Returned byte count comes from byte 8.
// - High test strap at power-up enters test mode; mode strap or choice bit high selects the reference-divider output.
// - Test mode holds until power cycles; writes cannot clear it.
// - With strap low, setting the test entry bit enters test mode.
// - Register-entered test mode uses only the choice bit for output.
// - Entry bit resets to 0; strap low and bit 0 means normal outputs.
// - Choice bit resets to 0, meaning high impedance.
`timescale 1ns/1ps
`default_nettype none
module sbcfg_port #(
	parameter logic [7:0] ID_VALUE = 8'h5a // Arbitrary identity value
) (
	input  wire logic                     sys_clk,
	input  wire logic                     resetn,
	input  wire logic                     scl_pin,
	input  wire logic                     sda_in,
	output logic                          sda_out,
	output logic                          sda_oe,
	input  wire logic                     test_sel_strap_pin,
	input  wire logic                     test_kind_strap_pin,
	output sbcfg_pkg::sbcfg_cfg_t         cfg_out,
	output sbcfg_pkg::sbcfg_out_mode_t    out_mode,
	output logic                          test_mode_active
);
	// ----------------------------------------
	// Pin sampling and bus conditions
	// ----------------------------------------
	logic [3:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       scl_prev_reg;
	logic       sda_prev_reg;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;

	sbcfg_sync #(
		.WIDTH(4)
	) u_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.async_in({test_kind_strap_pin, test_sel_strap_pin, sda_in, scl_pin}),
		.sync_out(pins_s)
	);

	assign scl_s     = pins_s[0];
	assign sda_s     = pins_s[1];
	assign scl_rise  = scl_s & ~scl_prev_reg;
	assign scl_fall  = ~scl_s & scl_prev_reg;
	assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	// Open drain: only ever pulls low
	assign sda_out   = 1'b0;

	// ----------------------------------------
	// Transfer state
	// ----------------------------------------
	sbcfg_pkg::sbcfg_state_t state_reg, state_next, after_reg, after_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] idx_reg, idx_next;
	logic [7:0] left_reg, left_next;
	logic       oe_reg, oe_next;
	logic       wr_en;
	logic       byte_done;
	logic [7:0] rd_byte;
	logic [7:0] cfg_reg [0:sbcfg_pkg::NUM_BYTES-1];

	assign byte_done = scl_fall && (bit_reg == sbcfg_pkg::BITS_PER_BYTE);
	// Out-of-range indices read as zero
	assign rd_byte   = (idx_reg < sbcfg_pkg::IDX_LIMIT) ? cfg_reg[idx_reg[3:0]] : 8'h00;

	always_comb
	begin
		state_next = state_reg;
		after_next = after_reg;
		bit_next   = bit_reg;
		shift_next = shift_reg;
		tx_next    = tx_reg;
		idx_next   = idx_reg;
		left_next  = left_reg;
		oe_next    = oe_reg;
		wr_en      = 1'b0;
		if (bus_stop)
		begin
			state_next = sbcfg_pkg::ST_IDLE;
			oe_next    = 1'b0;
		end
		else if (bus_start)
		begin
			// Repeated start lands here too, keeping the index
			state_next = sbcfg_pkg::ST_ADDR;
			bit_next   = 4'h0;
			oe_next    = 1'b0;
		end
		else
		begin
			unique case (state_reg)
				sbcfg_pkg::ST_IDLE, sbcfg_pkg::ST_IGNORE:
				begin
				end
				sbcfg_pkg::ST_ADDR, sbcfg_pkg::ST_INDEX, sbcfg_pkg::ST_COUNT, sbcfg_pkg::ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_next = {shift_reg[6:0], sda_s};
						bit_next   = bit_reg + 4'h1;
					end
					if (byte_done)
					begin
						bit_next   = 4'h0;
						oe_next    = 1'b1;
						state_next = sbcfg_pkg::ST_ACK;
						unique case (state_reg)
							sbcfg_pkg::ST_ADDR:
							begin
								if (shift_reg == sbcfg_pkg::ADDR_WR)
									after_next = sbcfg_pkg::ST_INDEX;
								else if (shift_reg == sbcfg_pkg::ADDR_RD)
								begin
									after_next = sbcfg_pkg::ST_RDATA;
									tx_next    = cfg_reg[sbcfg_pkg::IDX_COUNT];
									left_next  = cfg_reg[sbcfg_pkg::IDX_COUNT];
								end
								else
								begin
									oe_next    = 1'b0;
									state_next = sbcfg_pkg::ST_IGNORE;
								end
							end
							sbcfg_pkg::ST_INDEX:
							begin
								idx_next   = shift_reg;
								after_next = sbcfg_pkg::ST_COUNT;
							end
							sbcfg_pkg::ST_COUNT:
								after_next = sbcfg_pkg::ST_WDATA;
							default:
							begin
								wr_en      = 1'b1;
								idx_next   = idx_reg + 8'h01;
								after_next = sbcfg_pkg::ST_WDATA;
							end
						endcase
					end
				end
				sbcfg_pkg::ST_ACK:
				begin
					if (scl_fall)
					begin
						state_next = after_reg;
						oe_next    = (after_reg == sbcfg_pkg::ST_RDATA) ? ~tx_reg[7] : 1'b0;
					end
				end
				sbcfg_pkg::ST_RDATA:
				begin
					if (scl_rise)
						bit_next = bit_reg + 4'h1;
					if (byte_done)
					begin
						bit_next   = 4'h0;
						oe_next    = 1'b0;
						state_next = sbcfg_pkg::ST_RACK;
					end
					else if (scl_fall)
					begin
						tx_next = {tx_reg[6:0], 1'b1};
						oe_next = ~tx_reg[6];
					end
				end
				sbcfg_pkg::ST_RACK:
				begin
					if (scl_rise)
					begin
						if (sda_s)
							state_next = sbcfg_pkg::ST_IGNORE;
						else
						begin
							state_next = sbcfg_pkg::ST_RNEXT;
							// Past the count the bus idles high
							if (left_reg != 8'h00)
							begin
								tx_next   = rd_byte;
								idx_next  = idx_reg + 8'h01;
								left_next = left_reg - 8'h01;
							end
							else
								tx_next = sbcfg_pkg::FILL_BYTE;
						end
					end
				end
				sbcfg_pkg::ST_RNEXT:
				begin
					if (scl_fall)
					begin
						state_next = sbcfg_pkg::ST_RDATA;
						oe_next    = ~tx_reg[7];
					end
				end
				default:
					state_next = sbcfg_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_reg    <= sbcfg_pkg::ST_IDLE;
			after_reg    <= sbcfg_pkg::ST_IDLE;
			bit_reg      <= 4'h0;
			shift_reg    <= 8'h00;
			tx_reg       <= 8'h00;
			idx_reg      <= 8'h00;
			left_reg     <= 8'h00;
			oe_reg       <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			state_reg    <= state_next;
			after_reg    <= after_next;
			bit_reg      <= bit_next;
			shift_reg    <= shift_next;
			tx_reg       <= tx_next;
			idx_reg      <= idx_next;
			left_reg     <= left_next;
			oe_reg       <= oe_next;
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	assign sda_oe = oe_reg;

	// ----------------------------------------
	// Configuration bytes
	// ----------------------------------------
	for (genvar i = 0; i < sbcfg_pkg::NUM_BYTES; i++)
	begin : g_byte
		logic [7:0] byte_next;
		localparam logic [7:0] RST = (i == sbcfg_pkg::IDX_ID) ? ID_VALUE : sbcfg_pkg::RST_VAL[i];
		localparam logic [7:0] MSK = sbcfg_pkg::WR_MASK[i];

		always_comb
		begin
			byte_next = cfg_reg[i];
			if (wr_en && (idx_reg == 8'(i)))
				byte_next = (cfg_reg[i] & ~MSK) | (shift_reg & MSK);
		end

		always_ff @(posedge sys_clk or negedge resetn)
		begin
			if (!resetn)
				cfg_reg[i] <= RST;
			else
				cfg_reg[i] <= byte_next;
		end
	end

	assign cfg_out = {cfg_reg[0], cfg_reg[1], cfg_reg[2], cfg_reg[3]};

	// ----------------------------------------
	// Test mode
	// ----------------------------------------
	logic [1:0] settle_reg, settle_next;
	logic       strap_test_reg, strap_test_next;
	logic       sw_test_reg, sw_test_next;
	logic       choice_bit;
	sbcfg_pkg::sbcfg_out_mode_t mode_reg, mode_next;

	assign choice_bit = cfg_reg[sbcfg_pkg::IDX_TEST][sbcfg_pkg::POS_CHOICE];

	always_comb
	begin
		settle_next     = settle_reg;
		strap_test_next = strap_test_reg;
		sw_test_next    = sw_test_reg;
		// Strap caught once its synchroniser has filled after release
		if (settle_reg != sbcfg_pkg::STRAP_SETTLE)
		begin
			settle_next = settle_reg + 2'h1;
			if (settle_next == sbcfg_pkg::STRAP_SETTLE)
				strap_test_next = pins_s[2];
		end
		else if (!strap_test_reg && cfg_reg[sbcfg_pkg::IDX_TEST][sbcfg_pkg::POS_ENTRY])
			sw_test_next = 1'b1;
		if (strap_test_reg)
			mode_next = (pins_s[3] || choice_bit) ? sbcfg_pkg::OUT_REFDIV : sbcfg_pkg::OUT_HIZ;
		else if (sw_test_reg)
			mode_next = choice_bit ? sbcfg_pkg::OUT_REFDIV : sbcfg_pkg::OUT_HIZ;
		else
			mode_next = sbcfg_pkg::OUT_NORMAL;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			settle_reg     <= 2'h0;
			strap_test_reg <= 1'b0;
			sw_test_reg    <= 1'b0;
			mode_reg       <= sbcfg_pkg::OUT_NORMAL;
		end
		else
		begin
			settle_reg     <= settle_next;
			strap_test_reg <= strap_test_next;
			sw_test_reg    <= sw_test_next;
			mode_reg       <= mode_next;
		end
	end

	assign out_mode         = mode_reg;
	assign test_mode_active = strap_test_reg | sw_test_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic ev_quiet;
	assign ev_quiet = !bus_start && !bus_stop;

	a_ack_write_addr: assert property (state_reg == sbcfg_pkg::ST_ADDR && byte_done && ev_quiet && shift_reg == sbcfg_pkg::ADDR_WR |=> sda_oe && after_reg == sbcfg_pkg::ST_INDEX) else $error("write address not acknowledged");
	a_ack_read_addr: assert property (state_reg == sbcfg_pkg::ST_ADDR && byte_done && ev_quiet && shift_reg == sbcfg_pkg::ADDR_RD |=> sda_oe && state_reg == sbcfg_pkg::ST_ACK) else $error("read address not acknowledged");
	a_ack_index: assert property (state_reg == sbcfg_pkg::ST_INDEX && byte_done && ev_quiet |=> sda_oe && idx_reg == $past(shift_reg)) else $error("index byte not taken");
	a_ack_count: assert property (state_reg == sbcfg_pkg::ST_COUNT && byte_done && ev_quiet |=> sda_oe && after_reg == sbcfg_pkg::ST_WDATA) else $error("count not acknowledged");
	a_data_stored: assert property (wr_en && idx_reg == 8'(sbcfg_pkg::IDX_TEST) |=> cfg_reg[sbcfg_pkg::IDX_TEST] == (($past(shift_reg) & sbcfg_pkg::WR_MASK[sbcfg_pkg::IDX_TEST]) | ($past(cfg_reg[sbcfg_pkg::IDX_TEST]) & ~sbcfg_pkg::WR_MASK[sbcfg_pkg::IDX_TEST])) && sda_oe) else $error("data byte not stored");
	a_count_first: assert property (state_reg == sbcfg_pkg::ST_ADDR && byte_done && ev_quiet && shift_reg == sbcfg_pkg::ADDR_RD |=> tx_reg == cfg_reg[sbcfg_pkg::IDX_COUNT] && left_reg == cfg_reg[sbcfg_pkg::IDX_COUNT]) else $error("count byte not first");
	a_read_next: assert property (state_reg == sbcfg_pkg::ST_RACK && scl_rise && !sda_s && ev_quiet && left_reg != 8'h00 |=> tx_reg == $past(rd_byte) && idx_reg == $past(idx_reg) + 8'h01) else $error("read sequence broken");
	a_index_step: assert property (wr_en |=> idx_reg == $past(idx_reg) + 8'h01) else $error("index did not advance");
	a_test_sticky: assert property (test_mode_active |=> test_mode_active [*8]) else $error("test mode dropped");
	a_strap_output: assert property (strap_test_reg && pins_s[3] |=> out_mode == sbcfg_pkg::OUT_REFDIV) else $error("strap test output wrong");
	a_sw_choice: assert property (sw_test_reg && !strap_test_reg |=> out_mode == ($past(choice_bit) ? sbcfg_pkg::OUT_REFDIV : sbcfg_pkg::OUT_HIZ)) else $error("register test output wrong");
	a_normal_out: assert property (!test_mode_active |=> out_mode == sbcfg_pkg::OUT_NORMAL) else $error("normal output lost");

	c_block_write: cover property (wr_en ##[1:1000] bus_stop);
	c_block_read: cover property (state_reg == sbcfg_pkg::ST_RNEXT ##[1:1000] state_reg == sbcfg_pkg::ST_IGNORE);
	c_strap_test: cover property (strap_test_reg && out_mode == sbcfg_pkg::OUT_HIZ);
	c_sw_test: cover property (sw_test_reg && out_mode == sbcfg_pkg::OUT_REFDIV);
endmodule
`default_nettype wire

// ### sbcfg_port_tb.sv
/*
 * Self-checking bench for the configuration port and test-mode selection.
 * Assumes the host model in sbcfg_host_model.sv and a 200 MHz sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sbcfg_port_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [7:0] ID = 8'h5a; // Arbitrary identity value
	logic                      sys_clk = 1'b0;
	logic                      resetn = 1'b0;
	logic                      sel_strap = 1'b0;
	logic                      kind_strap = 1'b0;
	logic                      scl;
	logic                      host_pull;
	logic                      sda_out;
	logic                      sda_oe;
	logic                      res_valid;
	logic [8:0]                res_data;
	sbcfg_pkg::sbcfg_cfg_t     cfg_out;
	sbcfg_pkg::sbcfg_out_mode_t out_mode;
	logic                      test_mode_active;
	wire                       sda_wire = ~(host_pull | (sda_oe & ~sda_out));
	logic [8:0]                exp_q[$];
	logic [8:0]                exp_v;
	logic [7:0]                wbuf [0:8];
	logic [7:0]                rbuf [0:8];
	logic [31:0]               seed = 32'h0000004a;
	logic [31:0]               exp_cfg;
	int                        mismatches = 0;
	int                        compares = 0;
	int                        cycles = 0;

	always #2.5 sys_clk = ~sys_clk;

	sbcfg_port #(.ID_VALUE(ID)) uut (
		.sys_clk(sys_clk), .resetn(resetn), .scl_pin(scl), .sda_in(sda_wire), .sda_out(sda_out),
		.sda_oe(sda_oe), .test_sel_strap_pin(sel_strap), .test_kind_strap_pin(kind_strap),
		.cfg_out(cfg_out), .out_mode(out_mode), .test_mode_active(test_mode_active)
	);

	sbcfg_host_model host (
		.sys_clk(sys_clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(host_pull),
		.res_valid(res_valid), .res_data(res_data)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask

	// Straps held across release so the capture sees them settled
	task automatic pwr(input logic sel, input logic kind);
		@(posedge sys_clk);
		resetn <= 1'b0;
		sel_strap <= sel;
		kind_strap <= kind;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [7:0] b, input logic lvl);
		exp_q.push_back({lvl, b});
		host.put_byte(b);
	endtask

	task automatic write_regs(input logic [7:0] idx, input logic [7:0] n);
		host.start_c();
		wr(sbcfg_pkg::ADDR_WR, 1'b0);
		wr(idx, 1'b0);
		wr(n, 1'b0);
		for (int i = 0; i < n; i++)
			wr(wbuf[i], 1'b0);
		host.stop_c();
	endtask

	task automatic read_regs(input logic [7:0] idx, input int n);
		host.start_c();
		wr(sbcfg_pkg::ADDR_WR, 1'b0);
		wr(idx, 1'b0);
		host.start_c();
		wr(sbcfg_pkg::ADDR_RD, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			exp_q.push_back({i == n - 1, rbuf[i]});
			host.get_byte(i != n - 1);
		end
		host.stop_c();
	endtask

	// ----------------------------------------
	// Result watcher and timeout
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			mismatches++;
			end_of_test();
		end
		if (res_valid === 1'b1)
		begin
			exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1ff;
			check({23'h0, res_data}, {23'h0, exp_v});
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		pwr(1'b0, 1'b0);
		check(cfg_out, 32'hff9e3f55);
		check(out_mode, sbcfg_pkg::OUT_NORMAL);
		check(test_mode_active, 1'b0);
		$display("test reset done");
		host.start_c();
		wr(8'ha0, 1'b1);
		host.stop_c();
		$display("test foreign address done");
		seed = xs(seed);
		for (int i = 0; i < 4; i++)
			wbuf[i] = seed[8*i +: 8];
		exp_cfg = {wbuf[0], wbuf[1] & 8'h9e, wbuf[2] & 8'h3f, wbuf[3]};
		write_regs(8'h00, 8'h04);
		check(cfg_out, exp_cfg);
		$display("test block write done");
		wbuf[0] = 8'h04;
		write_regs(8'h08, 8'h01);
		rbuf[0] = 8'h04;
		for (int i = 0; i < 4; i++)
			rbuf[i + 1] = exp_cfg[31 - 8*i -: 8];
		read_regs(8'h00, 5);
		$display("test block read done");
		wbuf[0] = 8'h00;
		write_regs(8'h07, 8'h01);
		rbuf[0] = 8'h04;
		rbuf[1] = 8'h12;
		rbuf[2] = ID;
		rbuf[3] = 8'h04;
		rbuf[4] = 8'h00;
		read_regs(8'h06, 5);
		$display("test read only and past end done");
		@(posedge sys_clk);
		kind_strap <= 1'b1;
		wbuf[0] = 8'h40;
		write_regs(8'h06, 8'h01);
		check(test_mode_active, 1'b1);
		check(out_mode, sbcfg_pkg::OUT_HIZ);
		wbuf[0] = 8'hc0;
		write_regs(8'h06, 8'h01);
		check(out_mode, sbcfg_pkg::OUT_REFDIV);
		wbuf[0] = 8'h00;
		write_regs(8'h06, 8'h01);
		check(test_mode_active, 1'b1);
		check(out_mode, sbcfg_pkg::OUT_HIZ);
		$display("test register entry done");
		pwr(1'b1, 1'b1);
		check(out_mode, sbcfg_pkg::OUT_REFDIV);
		@(posedge sys_clk);
		kind_strap <= 1'b0;
		repeat (6) @(posedge sys_clk);
		check(out_mode, sbcfg_pkg::OUT_HIZ);
		wbuf[0] = 8'h80;
		write_regs(8'h06, 8'h01);
		check(out_mode, sbcfg_pkg::OUT_REFDIV);
		wbuf[0] = 8'h00;
		write_regs(8'h06, 8'h01);
		check(test_mode_active, 1'b1);
		$display("test strap entry done");
		pwr(1'b0, 1'b1);
		check(test_mode_active, 1'b0);
		check(out_mode, sbcfg_pkg::OUT_NORMAL);
		$display("test power cycle done");
		repeat (10) @(posedge sys_clk);
		check(exp_q.size(), 32'h0);
		end_of_test();
	end
endmodule
`default_nettype wire

// ### sbcfg_sync.sv
/*
 * Two-flop synchroniser for pins from outside the system clock domain.
 * Assumes the inputs are slow compared with sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sbcfg_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_next;

	always_comb
	begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_out <= sync_next;
		end
	end
endmodule
`default_nettype wire
